// >>> rtl/sae_sfr_ext.sv
// special-function-register address extension: map select, paging and access steering
// Summary of operation
// - only direct addresses 80h..FFh reach registers; lower addresses are ignored here
// - standard and mapped portions share 80h..FFh, with 8Fh common to both, giving 255 register locations
// - map-select bit of system_control_zero at 8Fh picks the portion, set means mapped
// - map-select bit holds until software writes it; software sets it before accesses
// - after the page field is rewritten, accesses at paged addresses go to that page
// - the page register keeps four save slots numbered 0 to 3
// - a save write stores the old page in the chosen slot, then loads the new page
// - timer unit page register at C7h standard, reset 00h, op/slot write-only, page readable
// - timer unit registers decode only while the map-select bit is clear
`timescale 1ns/1ps
module sae_sfr_ext
  import sae_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire sae_pkg::sae_byte_t sfr_addr_i,
  input  wire logic               sfr_wr_i,
  input  wire logic               sfr_rd_i,
  input  wire sae_pkg::sae_byte_t sfr_wdata_i,
  output sae_pkg::sae_byte_t      sfr_rdata_o,
  output logic                    sfr_rvalid_o,
  input  wire sae_pkg::sae_byte_t std_rdata_i,
  input  wire sae_pkg::sae_byte_t map_rdata_i,
  input  wire sae_pkg::sae_byte_t tu_rdata_i,
  output logic                    std_wr_o,
  output logic                    std_rd_o,
  output logic                    map_wr_o,
  output logic                    map_rd_o,
  output logic                    tu_wr_o,
  output logic                    tu_rd_o,
  output sae_pkg::sae_page_t      tu_page_o,
  output logic                    map_select_bit_o,
  output sae_pkg::sae_byte_t      sysctl_o
);
  import sae_pkg::*;

  // true for any address in the direct register window
  function automatic logic in_sfr_space(input sae_byte_t a);
    return (a >= SAE_SFR_BASE) && (a <= SAE_SFR_TOP);
  endfunction

  // true for the paged register block of the timer unit
  function automatic logic in_tu_block(input sae_byte_t a);
    return (a >= SAE_TU_FIRST_ADDR) && (a <= SAE_TU_LAST_ADDR);
  endfunction

  sae_byte_t sysctl_q;
  sae_byte_t rdata_q;
  logic      rvalid_q;
  logic      map_sel;
  logic      hit_sfr;
  logic      hit_sysctl;
  logic      hit_tu_page;
  logic      hit_tu;
  logic      hit_std_other;
  logic      hit_map_other;
  logic      tu_page_wr;
  sae_byte_t tu_page_rdata;
  sae_byte_t rdata_d;

  assign map_sel = sysctl_q[SAE_MAP_SEL_POS];

  // address decode
  assign hit_sfr     = in_sfr_space(sfr_addr_i);
  // the control register stays reachable in both portions so software can always leave a portion
  assign hit_sysctl  = hit_sfr && (sfr_addr_i == SAE_SYSCTL_ADDR);
  assign hit_tu_page = hit_sfr && !map_sel && (sfr_addr_i == SAE_TU_PAGE_ADDR);
  assign hit_tu      = hit_sfr && !map_sel && in_tu_block(sfr_addr_i);
  assign hit_std_other = hit_sfr && !map_sel && !hit_sysctl && !hit_tu_page && !hit_tu;
  assign hit_map_other = hit_sfr && map_sel && !hit_sysctl;

  // strobes towards the peripherals; combinational so a peripheral sees the access in its own cycle
  assign std_wr_o = sfr_wr_i && hit_std_other;
  assign std_rd_o = sfr_rd_i && hit_std_other;
  assign map_wr_o = sfr_wr_i && hit_map_other;
  assign map_rd_o = sfr_rd_i && hit_map_other;
  assign tu_wr_o  = sfr_wr_i && hit_tu;
  assign tu_rd_o  = sfr_rd_i && hit_tu;

  assign tu_page_wr = sfr_wr_i && hit_tu_page;

  // the map-select bit is changed only by a software write or by reset
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sysctl_q <= SAE_SYSCTL_RESET;
    end
    else if (sfr_wr_i && hit_sysctl)
    begin
      sysctl_q <= sfr_wdata_i;
    end
  end

  sae_page_reg u_tu_page (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .wr_i    (tu_page_wr),
    .wdata_i (sfr_wdata_i),
    .page_o  (tu_page_o),
    .rdata_o (tu_page_rdata)
  );

  // read source selection; addresses below the window answer zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (hit_sysctl)
    begin
      rdata_d = sysctl_q;
    end
    else if (hit_tu_page)
    begin
      rdata_d = tu_page_rdata;
    end
    else if (hit_tu)
    begin
      rdata_d = tu_rdata_i;
    end
    else if (hit_std_other)
    begin
      rdata_d = std_rdata_i;
    end
    else if (hit_map_other)
    begin
      rdata_d = map_rdata_i;
    end
  end

  // read data is registered: one cycle of latency in exchange for a clean output
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      rdata_q <= 8'h00;
    end
    else if (sfr_rd_i)
    begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= sfr_rd_i;
    end
  end

  assign sfr_rdata_o      = rdata_q;
  assign sfr_rvalid_o     = rvalid_q;
  assign map_select_bit_o = map_sel;
  assign sysctl_o         = sysctl_q;

endmodule // sae_sfr_ext

// >>> include/sae_pkg.sv
// constants and types shared by the special-function-register address extension block
package sae_pkg;

  typedef logic [7:0] sae_byte_t;
  typedef logic [2:0] sae_page_t;
  typedef logic [1:0] sae_slot_t;
  typedef logic [1:0] sae_op_t;

  // direct addressing window of the register space
  localparam sae_byte_t SAE_SFR_BASE      = 8'h80;
  localparam sae_byte_t SAE_SFR_TOP       = 8'hFF;

  // register offsets
  localparam sae_byte_t SAE_SYSCTL_ADDR   = 8'h8F;
  localparam sae_byte_t SAE_TU_PAGE_ADDR  = 8'hC7;

  // capture/compare timer unit register block (paged, standard portion only)
  localparam sae_byte_t SAE_TU_FIRST_ADDR = 8'hC0;
  localparam sae_byte_t SAE_TU_LAST_ADDR  = 8'hC6;

  // system_control_zero fields
  localparam int        SAE_MAP_SEL_POS   = 0;
  localparam sae_byte_t SAE_SYSCTL_RESET  = 8'h00;

  // timer_unit_page_select fields
  localparam int        SAE_OP_MSB        = 7;
  localparam int        SAE_OP_LSB        = 6;
  localparam int        SAE_SLOT_MSB      = 5;
  localparam int        SAE_SLOT_LSB      = 4;
  localparam int        SAE_PAGE_MSB      = 2;
  localparam int        SAE_PAGE_LSB      = 0;
  localparam sae_byte_t SAE_TU_PAGE_RESET = 8'h00;
  localparam sae_page_t SAE_PAGE_RESET    = 3'h0;
  localparam int        SAE_NUM_SLOTS     = 4;

  // page operation codes
  localparam sae_op_t   SAE_OP_SAVE       = 2'h2;
  localparam sae_op_t   SAE_OP_RESTORE    = 2'h3;

endpackage

// >>> rtl/sae_page_reg.sv
// page register with four save slots for one paged peripheral unit
`timescale 1ns/1ps
module sae_page_reg
  import sae_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic               wr_i,
  input  wire sae_pkg::sae_byte_t wdata_i,
  output sae_pkg::sae_page_t      page_o,
  output sae_pkg::sae_byte_t      rdata_o
);
  import sae_pkg::*;

  sae_page_t page_q;
  sae_page_t slot_q [SAE_NUM_SLOTS];
  sae_op_t   op;
  sae_slot_t slot_nr;
  sae_page_t new_page;

  assign op       = wdata_i[SAE_OP_MSB:SAE_OP_LSB];
  assign slot_nr  = wdata_i[SAE_SLOT_MSB:SAE_SLOT_LSB];
  assign new_page = wdata_i[SAE_PAGE_MSB:SAE_PAGE_LSB];

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      page_q <= SAE_PAGE_RESET;
    end
    else if (wr_i)
    begin
      if (op == SAE_OP_RESTORE)
      begin
        page_q <= slot_q[slot_nr];
      end
      else
      begin
        page_q <= new_page;
      end
    end
  end

  // the save slot takes the page value from before this write, so save and load happen in one access
  for (genvar s = 0; s < SAE_NUM_SLOTS; s++)
  begin : g_slot
    always_ff @(posedge clk_i)
    begin
      if (!rst_b_i)
      begin
        slot_q[s] <= SAE_PAGE_RESET;
      end
      else if (wr_i && op == SAE_OP_SAVE && slot_nr == sae_slot_t'(s))
      begin
        slot_q[s] <= page_q;
      end
    end
  end

  assign page_o = page_q;

  // operation and slot fields are write-only and read as zero
  always_comb
  begin
    rdata_o                            = SAE_TU_PAGE_RESET;
    rdata_o[SAE_PAGE_MSB:SAE_PAGE_LSB] = page_q;
  end

endmodule // sae_page_reg

// >>> tb/sae_sfr_ext_assertions.sv
// concurrent checks on the ports of the register address extension block
`timescale 1ns/1ps
module sae_sfr_ext_assertions
  import sae_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               rst_b_i,
  input wire sae_pkg::sae_byte_t sfr_addr_i,
  input wire logic               sfr_wr_i,
  input wire logic               sfr_rd_i,
  input wire sae_pkg::sae_byte_t sfr_wdata_i,
  input wire sae_pkg::sae_byte_t sfr_rdata_o,
  input wire logic               sfr_rvalid_o,
  input wire logic               std_wr_o,
  input wire logic               std_rd_o,
  input wire logic               map_wr_o,
  input wire logic               map_rd_o,
  input wire logic               tu_wr_o,
  input wire logic               tu_rd_o,
  input wire sae_pkg::sae_page_t tu_page_o,
  input wire logic               map_select_bit_o,
  input wire sae_pkg::sae_byte_t sysctl_o
);
  import sae_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire hi = sfr_addr_i[7];
  wire sy = sfr_addr_i == SAE_SYSCTL_ADDR;
  wire pg = sfr_addr_i == SAE_TU_PAGE_ADDR && !map_select_bit_o;
  wire tw = sfr_wr_i && pg;
  chk_low_quiet: assert property (!hi |-> !(std_wr_o|std_rd_o|map_wr_o|map_rd_o|tu_wr_o|tu_rd_o))
    else $error("strobe below 80h");
  chk_low_read: assert property (sfr_rd_i && !hi |=> sfr_rdata_o == 8'h00 && sfr_rvalid_o)
    else $error("low read not zero");
  chk_map_steer: assert property (sfr_wr_i && hi && !sy && map_select_bit_o |-> map_wr_o && !std_wr_o && !tu_wr_o)
    else $error("mapped write misrouted");
  chk_tu_steer: assert property (sfr_rd_i && !map_select_bit_o && sfr_addr_i inside {[8'hC0:8'hC6]}
    |-> tu_rd_o && !std_rd_o && !map_rd_o) else $error("timer read misrouted");
  chk_map_hold: assert property (!(sfr_wr_i && sy) |=> $stable(map_select_bit_o))
    else $error("map bit changed alone");
  chk_sysctl_write: assert property (sfr_wr_i && sy |=> sysctl_o == $past(sfr_wdata_i))
    else $error("control write lost");
  chk_page_load: assert property (tw && sfr_wdata_i[7:6] != SAE_OP_RESTORE
    |=> tu_page_o == $past(sfr_wdata_i[2:0])) else $error("page not loaded");
  chk_page_hold: assert property (!tw |=> $stable(tu_page_o))
    else $error("page changed alone");
  chk_page_read: assert property (sfr_rd_i && pg |=> sfr_rdata_o == {5'h00, $past(tu_page_o)})
    else $error("page read wrong");
  cov_save: cover property (tw && sfr_wdata_i[7:6] == SAE_OP_SAVE);
  cov_restore: cover property (tw && sfr_wdata_i[7:6] == SAE_OP_RESTORE);
  cov_map_on: cover property (sfr_wr_i && sy && sfr_wdata_i[0]);
endmodule // sae_sfr_ext_assertions

bind sae_sfr_ext sae_sfr_ext_assertions u_chk (.*);

// >>> tb/sae_periph_model.sv
// peripheral read-data responder behind the portion strobes
`timescale 1ns/1ps
module sae_periph_model
  import sae_pkg::*;
(
  input  wire sae_pkg::sae_byte_t addr_i,
  input  wire logic               std_rd_i,
  input  wire logic               map_rd_i,
  input  wire logic               tu_rd_i,
  input  wire sae_pkg::sae_page_t page_i,
  output sae_pkg::sae_byte_t      std_rdata_o,
  output sae_pkg::sae_byte_t      map_rdata_o,
  output sae_pkg::sae_byte_t      tu_rdata_o
);
  import sae_pkg::*;
  // unselected outputs show the inverted address so stale data cannot pass
  assign std_rdata_o = std_rd_i ? addr_i ^ 8'h5A : ~addr_i;
  assign map_rdata_o = map_rd_i ? addr_i ^ 8'hA5 : ~addr_i;
  assign tu_rdata_o  = tu_rd_i ? {page_i, addr_i[4:0]} : ~addr_i;
endmodule // sae_periph_model

// >>> tb/testbench.sv
// self-checking bench for the register address extension block
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((e) !== (a)) begin errors++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module testbench;
  import sae_pkg::*;
  logic      clk_i = 0, rst_b_i = 0, sfr_wr_i = 0, sfr_rd_i = 0, sfr_rvalid_o, map_select_bit_o;
  logic      std_wr_o, std_rd_o, map_wr_o, map_rd_o, tu_wr_o, tu_rd_o;
  sae_byte_t sfr_addr_i = '0, sfr_wdata_i = '0, sfr_rdata_o, std_rdata_i, map_rdata_i, tu_rdata_i, sysctl_o, ex;
  sae_page_t tu_page_o, pg, np, sv [4];
  sae_byte_t expq [$];
  int        errors = 0, checked = 0;
  sae_sfr_ext i_dut (.*);
  sae_periph_model i_periph (.addr_i(sfr_addr_i), .std_rd_i(std_rd_o), .map_rd_i(map_rd_o), .tu_rd_i(tu_rd_o),
    .page_i(tu_page_o), .std_rdata_o(std_rdata_i), .map_rdata_o(map_rdata_i), .tu_rdata_o(tu_rdata_i));
  initial forever #2 clk_i = ~clk_i;
  task automatic acc(input logic w, input sae_byte_t a, input sae_byte_t d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_wr_i = w;
    sfr_rd_i = !w;
    sfr_wdata_i = d;
    @(negedge clk_i);
    sfr_wr_i = 0;
    sfr_rd_i = 0;
  endtask
  task automatic rd(input sae_byte_t a, input sae_byte_t e);
    expq.push_back(e);
    acc(0, a, 8'h00);
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // every read answer is paired with the oldest expectation
  always @(negedge clk_i)
    if (sfr_rvalid_o === 1'b1)
    begin
      ex = (expq.size() > 0) ? expq.pop_front() : 8'hXX;
      `CHK("rdata", ex, sfr_rdata_o)
    end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(32'h44bc));
    repeat (5) @(negedge clk_i);
    rst_b_i = 1;
    pg = 3'h0;
    `CHK("page", 3'h0, tu_page_o)
    rd(SAE_SYSCTL_ADDR, 8'h00);
    rd(SAE_TU_PAGE_ADDR, 8'h00);
    rd(8'h40, 8'h00);
    acc(1, 8'h47, 8'h03);
    `CHK("low write", 3'h0, tu_page_o)
    rd(8'hA0, 8'hA0 ^ 8'h5A);
    acc(1, SAE_SYSCTL_ADDR, 8'h01);
    `CHK("map bit", 1'b1, map_select_bit_o)
    rd(8'hA0, 8'hA0 ^ 8'hA5);
    rd(SAE_TU_PAGE_ADDR, SAE_TU_PAGE_ADDR ^ 8'hA5);
    acc(1, SAE_TU_PAGE_ADDR, 8'h07);
    `CHK("mapped page", 3'h0, tu_page_o)
    acc(1, SAE_SYSCTL_ADDR, 8'h00);
    for (int op = 0; op < 2; op++)
    begin
      np = 3'($urandom);
      acc(1, SAE_TU_PAGE_ADDR, {2'(op), 2'($urandom), 1'b1, np});
      pg = np;
      rd(SAE_TU_PAGE_ADDR, {5'h00, pg});
    end
    // interrupt style nesting: save into each slot, then unwind
    for (int s = 0; s < SAE_NUM_SLOTS; s++)
    begin
      np = 3'($urandom);
      acc(1, SAE_TU_PAGE_ADDR, {SAE_OP_SAVE, 2'(s), 1'b0, np});
      sv[s] = pg;
      pg = np;
      `CHK("save page", pg, tu_page_o)
    end
    for (int s = SAE_NUM_SLOTS - 1; s >= 0; s--)
    begin
      acc(1, SAE_TU_PAGE_ADDR, {SAE_OP_RESTORE, 2'(s), 1'b0, 3'($urandom)});
      pg = sv[s];
      `CHK("restore page", pg, tu_page_o)
      rd(8'hC3, {pg, 5'h03});
    end
    rst_b_i = 0;
    @(negedge clk_i);
    rst_b_i = 1;
    `CHK("reset page", 3'h0, tu_page_o)
    `CHK("reset ctl", 8'h00, sysctl_o)
    @(negedge clk_i);
    `CHK("pending", 0, expq.size())
    tally_and_finish();
  end
endmodule // testbench
